// ==== mii_management_unit.sv ====
`timescale 1ns/100ps
// Functional notes
// - operation bits start a frame, self-clear after
// - control bits 13..9 give PHY address
// - control bits 8..4 give register address
// - answered flag when PHY drives low after idle
// - answered flag clears on control read or on a read start
// - bit 1 sends write frame with data
// - bit 0 reads PHY bits into data
// - 16-bit data register for both directions
// - config bits 15,14 pick transmit clock source
// - alternate direction set makes pin input
// - bit 6 reads pin, drives when output
// - alternate clock bit drives clock pin
// - bit 4 selects engine or alternate; resets one
// - PHY present reads data line high
// - bit 2 reads companion link pin
// - bit 1 drives companion enable pin
// - bit 0 selects seven-wire serial mode
module mii_management_unit import mii_mgmt_pkg::*; #(
  parameter int HALF_CYCLES = MDC_HALF_CYCLES
) (
  input wire logic ref_clk, // system clock, 250 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic mii_tx_clk, // transmit clock from the link
  input wire logic [7:0] reg_addr, // register byte offset
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [31:0] reg_wdata, // register write data
  output logic [31:0] reg_rdata, // register read data, held
  input wire logic mdio_i, // management data pin level
  output logic mdio_o, // management data pin drive value
  output logic mdio_oe, // management data pin drive enable
  output logic serial_mgmt_clock, // management clock pin
  input wire logic companion_xcvr_link_pin, // companion link status pin
  output logic companion_xcvr_enable_pin, // companion enable pin
  output logic serial_mode_tx // seven-wire mode, transmit domain
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYCLES - 1);

  eng_state_e state_r, state_nxt;
  logic [CW-1:0] phase_r, phase_nxt;
  logic [5:0] bit_idx_r, bit_idx_nxt;
  logic [FRAME_BITS-1:0] frame_r, frame_nxt;
  logic [DATA_W-1:0] rd_shift_r, rd_shift_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic [ADDR_W-1:0] phyad_r, phyad_nxt;
  logic [ADDR_W-1:0] regad_r, regad_nxt;
  logic rd_busy_r, rd_busy_nxt;
  logic wr_busy_r, wr_busy_nxt;
  logic answered_r, answered_nxt;
  logic mdc_r, mdc_nxt;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic mdio_s, link_s;
  logic [31:0] rdata_nxt;

  // pin levels cross into the system clock domain
  sync2 #(.W(2)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({mdio_i, companion_xcvr_link_pin}),
    .q({mdio_s, link_s})
  );

  // transmit-side logic lives on its own clock; only the mode bit crosses
  tx_clock_domain u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mii_tx_clk(mii_tx_clk),
    .sel_en(cfg_r[CFG_TXCLK_SEL_BIT]),
    .sel_sys(cfg_r[CFG_TXCLK_SYS_BIT]),
    .serial_mode(cfg_r[CFG_SERIAL_MODE_BIT]),
    .serial_mode_tx(serial_mode_tx)
  );

  // register decode
  wire ctrl_hit = (reg_addr == CTRL_OFFSET);
  wire data_hit = (reg_addr == DATA_OFFSET);
  wire cfg_hit = (reg_addr == CFG_OFFSET);
  wire ctrl_wr = reg_wr & ctrl_hit;
  wire data_wr = reg_wr & data_hit;
  wire cfg_wr = reg_wr & cfg_hit;
  wire ctrl_rd = reg_rd & ctrl_hit;

  // engine decode; a start is only taken while idle, read wins a tie
  wire idle = (state_r == ST_IDLE);
  wire start_rd = idle & ctrl_wr & reg_wdata[CTRL_READ_BIT];
  wire start_wr = idle & ctrl_wr & reg_wdata[CTRL_WRITE_BIT] & ~start_rd;
  wire start = start_rd | start_wr;
  wire phase_end = (phase_r == HALF_LAST);
  wire rise = (state_r == ST_LOW) & phase_end;
  wire fall = (state_r == ST_HIGH) & phase_end;
  wire last_bit = (bit_idx_r == LAST_BIT);
  wire done = fall & last_bit;
  wire answer_seen = rise & rd_busy_r & (bit_idx_r == ANSWER_BIT) & ~mdio_s;
  wire data_sample = rise & rd_busy_r & (bit_idx_r >= DATA_FIRST_BIT);
  wire mgmt_en = cfg_r[CFG_MGMT_EN_BIT];

  // frame built from the fields latched at start
  wire [ADDR_W-1:0] phyad_new = ctrl_wr ?
    reg_wdata[CTRL_PHYAD_LSB +: ADDR_W] : phyad_r;
  wire [ADDR_W-1:0] regad_new = ctrl_wr ?
    reg_wdata[CTRL_REGAD_LSB +: ADDR_W] : regad_r;
  wire [FRAME_BITS-1:0] frame_new = start_rd ?
    {PREAMBLE, START_PAT, OP_READ, phyad_new, regad_new, TA_READ, 16'hFFFF} :
    {PREAMBLE, START_PAT, OP_WRITE, phyad_new, regad_new, TA_WRITE, data_r};

  // engine drives the line up to the idle turnaround bit on reads
  wire eng_oe = ~idle & (wr_busy_r | (bit_idx_r < TA_IDLE_BIT));
  wire eng_mdo = frame_r[FRAME_BITS-1];

  // address fields may change any time; a running frame holds its copy
  assign phyad_nxt = phyad_new;
  assign regad_nxt = regad_new;

  // state sequencing: low half, then high half, per bit
  assign state_nxt = start ? ST_LOW :
    rise ? ST_HIGH :
    done ? ST_IDLE :
    fall ? ST_LOW : state_r;
  assign phase_nxt = (start | phase_end | idle) ? '0 : phase_r + 1'b1;
  assign mdc_nxt = rise ? 1'b1 : (fall | start) ? 1'b0 : mdc_r;
  assign bit_idx_nxt = start ? '0 : (fall & ~last_bit) ? bit_idx_r + 1'b1 : bit_idx_r;
  // outgoing bit moves on the falling edge, far from the sampling edge
  assign frame_nxt = start ? frame_new :
    fall ? {frame_r[FRAME_BITS-2:0], 1'b0} : frame_r;
  assign rd_shift_nxt = data_sample ?
    {rd_shift_r[DATA_W-2:0], mdio_s} : rd_shift_r;

  // operation bits stay set for the whole frame
  assign rd_busy_nxt = start_rd | (rd_busy_r & ~done);
  assign wr_busy_nxt = start_wr | (wr_busy_r & ~done);

  // data register: software write, or returned bits at end of a read
  assign data_nxt = (done & rd_busy_r) ? rd_shift_nxt :
    data_wr ? reg_wdata[DATA_W-1:0] : data_r;

  // answered flag: a new answer wins over the read that clears it
  assign answered_nxt = answer_seen ? 1'b1 :
    (ctrl_rd | start_rd) ? 1'b0 : answered_r;

  // configuration: only writable bits take the written value
  assign cfg_nxt = cfg_wr ?
    ((reg_wdata[CFG_W-1:0] & CFG_WR_MASK) | (cfg_r & ~CFG_WR_MASK)) : cfg_r;

  // read data multiplexer; unmapped offsets read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] a,
                                           input logic [31:0] c,
                                           input logic [31:0] d,
                                           input logic [31:0] f);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == CTRL_OFFSET) begin
      r = c;
    end else if (a == DATA_OFFSET) begin
      r = d;
    end else if (a == CFG_OFFSET) begin
      r = f;
    end
    return r;
  endfunction

  wire [31:0] ctrl_view = {18'h00000, phyad_r, regad_r, answered_r, 1'b0,
    wr_busy_r, rd_busy_r};
  wire [31:0] data_view = {16'h0000, data_r};
  wire [31:0] cfg_view = {16'h0000,
    cfg_r[CFG_TXCLK_SYS_BIT], cfg_r[CFG_TXCLK_SEL_BIT], 6'h00,
    cfg_r[CFG_ALT_DIR_BIT],
    mdio_s,
    cfg_r[CFG_ALT_CLK_BIT], cfg_r[CFG_MGMT_EN_BIT],
    mdio_s,
    link_s,
    cfg_r[CFG_XCVR_EN_BIT], cfg_r[CFG_SERIAL_MODE_BIT]};
  assign rdata_nxt = reg_rd ? read_mux(reg_addr, ctrl_view, data_view, cfg_view) : reg_rdata;

  // pin muxing: engine or alternate bits, registered so pins never glitch
  wire clk_pin_nxt = mgmt_en ? mdc_r : cfg_r[CFG_ALT_CLK_BIT];
  wire mdio_o_nxt = mgmt_en ? eng_mdo : cfg_r[CFG_ALT_DATA_BIT];
  wire mdio_oe_nxt = mgmt_en ? eng_oe : ~cfg_r[CFG_ALT_DIR_BIT];

  // engine state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // half-period counter of the management clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // bit position within the frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx_r <= '0;
    end else begin
      bit_idx_r <= bit_idx_nxt;
    end
  end

  // internal management clock, one cycle ahead of its pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_r <= 1'b0;
    end else begin
      mdc_r <= mdc_nxt;
    end
  end

  // outgoing frame, shifted out from the top
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= '0;
    end else begin
      frame_r <= frame_nxt;
    end
  end

  // returned bits gather here until the frame ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_shift_r <= '0;
    end else begin
      rd_shift_r <= rd_shift_nxt;
    end
  end

  // phy address field, kept for read-back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyad_r <= '0;
    end else begin
      phyad_r <= phyad_nxt;
    end
  end

  // register address field, kept for read-back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regad_r <= '0;
    end else begin
      regad_r <= regad_nxt;
    end
  end

  // read operation bit, cleared by hardware at frame end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_busy_r <= 1'b0;
    end else begin
      rd_busy_r <= rd_busy_nxt;
    end
  end

  // write operation bit, cleared by hardware at frame end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_busy_r <= 1'b0;
    end else begin
      wr_busy_r <= wr_busy_nxt;
    end
  end

  // answered flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      answered_r <= 1'b0;
    end else begin
      answered_r <= answered_nxt;
    end
  end

  // frame data register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
    end else begin
      data_r <= data_nxt;
    end
  end

  // configuration; reset hands the pins to the engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // read data stays until the next read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // pins come from flops so a source change never glitches them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mgmt_clock <= 1'b0;
    end else begin
      serial_mgmt_clock <= clk_pin_nxt;
    end
  end

  // data pin drive value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_o <= 1'b0;
    end else begin
      mdio_o <= mdio_o_nxt;
    end
  end

  // data pin enable; released when idle so a present phy can be seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_oe <= 1'b0;
    end else begin
      mdio_oe <= mdio_oe_nxt;
    end
  end

  // companion enable pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      companion_xcvr_enable_pin <= 1'b0;
    end else begin
      companion_xcvr_enable_pin <= cfg_r[CFG_XCVR_EN_BIT];
    end
  end
endmodule

// ==== mii_mgmt_pkg.sv ====
package mii_mgmt_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h30;
  localparam logic [7:0] DATA_OFFSET = 8'h34;
  localparam logic [7:0] CFG_OFFSET = 8'h38;

  // command/control register fields
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_ANSWERED_BIT = 3;
  localparam int CTRL_REGAD_LSB = 4;
  localparam int CTRL_PHYAD_LSB = 9;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // configuration register fields
  localparam int CFG_SERIAL_MODE_BIT = 0;
  localparam int CFG_XCVR_EN_BIT = 1;
  localparam int CFG_LINK_BIT = 2;
  localparam int CFG_PHY_PRESENT_BIT = 3;
  localparam int CFG_MGMT_EN_BIT = 4;
  localparam int CFG_ALT_CLK_BIT = 5;
  localparam int CFG_ALT_DATA_BIT = 6;
  localparam int CFG_ALT_DIR_BIT = 7;
  localparam int CFG_TXCLK_SEL_BIT = 14;
  localparam int CFG_TXCLK_SYS_BIT = 15;
  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0010;
  localparam logic [15:0] CFG_WR_MASK = 16'hC0F3;

  // management frame layout, most significant bit first
  localparam int FRAME_BITS = 64;
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] START_PAT = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h3;
  localparam logic [5:0] TA_IDLE_BIT = 6'h2E;
  localparam logic [5:0] ANSWER_BIT = 6'h2F;
  localparam logic [5:0] DATA_FIRST_BIT = 6'h30;
  localparam logic [5:0] LAST_BIT = 6'h3F;

  // management clock timing
  localparam int REF_CLK_PERIOD_NS = 4;
  localparam int MDC_MIN_PERIOD_NS = 400;
  localparam int MDC_HALF_CYCLES =
    (MDC_MIN_PERIOD_NS + 2 * REF_CLK_PERIOD_NS - 1) / (2 * REF_CLK_PERIOD_NS);

  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOW = 3'h2,
    ST_HIGH = 3'h4
  } eng_state_e;

endpackage

// ==== sync2.sv ====
`timescale 1ns/100ps
// two-stage level synchroniser; only stage two is visible
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== tx_clock_domain.sv ====
`timescale 1ns/100ps
// transmit-clocked registers and their clock source choice
module tx_clock_domain (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic mii_tx_clk, // transmit clock from the link
  input wire logic sel_en, // clock source choice enabled
  input wire logic sel_sys, // choose inverted system clock
  input wire logic serial_mode, // seven-wire mode, system domain
  output logic serial_mode_tx // seven-wire mode, transmit domain
);
  logic tx_core_clk;
  logic serial_mode_s;

  // glitch risk on the switch is accepted: software changes it only while idle
  assign tx_core_clk = (sel_en & sel_sys) ? ~ref_clk : mii_tx_clk;

  sync2 #(.W(1)) u_mode_sync (
    .clk(tx_core_clk),
    .rst_n(rst_n),
    .d(serial_mode),
    .q(serial_mode_s)
  );

  // mode flop runs on whichever transmit clock is selected
  always_ff @(posedge tx_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode_tx <= 1'b0;
    end else begin
      serial_mode_tx <= serial_mode_s;
    end
  end
endmodule

// ==== mii_mgmt_chk.sv ====
`timescale 1ns/100ps
// pin and register-bus checks for the management unit
module mii_mgmt_chk import mii_mgmt_pkg::*; #(
  parameter int HALF_CYCLES = MDC_HALF_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic mii_tx_clk, // link clock
  input wire logic [7:0] reg_addr, // offset
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_wdata, // write data
  input wire logic [31:0] reg_rdata, // read data
  input wire logic mdio_i, // data pin level
  input wire logic mdio_o, // data drive
  input wire logic mdio_oe, // data enable
  input wire logic serial_mgmt_clock, // clock pin
  input wire logic companion_xcvr_link_pin, // link pin
  input wire logic companion_xcvr_enable_pin, // enable pin
  input wire logic serial_mode_tx // tx domain mode
);
  logic mgmt_en_r; // engine owns the pins; mirrored from cfg writes, not read back
  wire cfg_wr = reg_wr && reg_addr == CFG_OFFSET;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) mgmt_en_r <= 1'b1;
    else if (cfg_wr) mgmt_en_r <= reg_wdata[CFG_MGMT_EN_BIT];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_alt_wr; cfg_wr && !reg_wdata[CFG_MGMT_EN_BIT]; endsequence
  sequence s_ctrl_rd; reg_rd && reg_addr == CTRL_OFFSET; endsequence
  // pins follow a cfg write two edges later: register first, then pin flop
  property p_en;
    cfg_wr |-> ##2 companion_xcvr_enable_pin == $past(reg_wdata[CFG_XCVR_EN_BIT], 2);
  endproperty
  a_en: assert property (p_en) else $error("enable pin wrong");
  property p_alt_clk;
    s_alt_wr |-> ##2 serial_mgmt_clock == $past(reg_wdata[CFG_ALT_CLK_BIT], 2);
  endproperty
  a_alt_clk: assert property (p_alt_clk) else $error("alt clock wrong");
  property p_alt_dir;
    s_alt_wr |-> ##2 mdio_oe == !$past(reg_wdata[CFG_ALT_DIR_BIT], 2);
  endproperty
  a_alt_dir: assert property (p_alt_dir) else $error("alt direction wrong");
  // both halves of the divided clock last two cycles or more
  property p_clk_hi; mgmt_en_r && $rose(serial_mgmt_clock) |-> serial_mgmt_clock [*2]; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("clock high too short");
  property p_clk_lo; mgmt_en_r && $fell(serial_mgmt_clock) |-> (!serial_mgmt_clock) [*2];
  endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("clock low too short");
  property p_stable; mgmt_en_r && mdio_oe && $rose(serial_mgmt_clock) |-> $stable(mdio_o);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved at clock rise");
  property p_pre; mgmt_en_r && $rose(mdio_oe) |-> mdio_o [*8]; endproperty
  a_pre: assert property (p_pre) else $error("frame not opened by ones");
  // a frame in flight may set the flag again, so busy excuses it
  property p_flag_clr;
    s_ctrl_rd ##1 s_ctrl_rd |=> !reg_rdata[CTRL_ANSWERED_BIT] || reg_rdata[CTRL_READ_BIT];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("answered flag kept");
endmodule
bind mii_management_unit mii_mgmt_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.ref_clk, .rst_n,
  .mii_tx_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mdio_i, .mdio_o, .mdio_oe,
  .serial_mgmt_clock, .companion_xcvr_link_pin, .companion_xcvr_enable_pin, .serial_mode_tx);

// ==== phy_mgmt_model.sv ====
`timescale 1ns/100ps
// management side of a PHY: answers reads to its own address only
module phy_mgmt_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic [15:0] ANSWER = 16'h0000
) (
  input wire logic rst_n, // async reset
  input wire logic mdc, // management clock
  input wire logic mdio, // resolved data line
  output logic drv_o, // drive value
  output logic drv_oe // drive enable
);
  logic [15:0] sh_r;
  logic [4:0] k_r;
  wire [15:0] seen = {sh_r[14:0], mdio};
  // preamble tail, start, read opcode, own address
  wire hit = seen[15:5] == {2'b11, 2'b01, 2'b10, PHY_ADDR};
  // change just after the rising edge the device samples on
  always @(posedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= '0;
      k_r <= '0;
      drv_o <= 1'b1;
      drv_oe <= 1'b0;
    end else begin
      sh_r <= seen;
      if (k_r != 5'd0) k_r <= k_r - 5'd1;
      else if (hit) k_r <= 5'd18;
      drv_oe <= k_r >= 5'd2;
      drv_o <= (k_r == 5'd18) ? 1'b0 : ANSWER[4'(k_r - 5'd2)];
    end
  end
endmodule

// ==== test_mii_management_unit.sv ====
`timescale 1ns/100ps
module test_mii_management_unit import mii_mgmt_pkg::*;;
  localparam logic [4:0] PHY = 5'h11;
  localparam logic [15:0] ANS = 16'h3C96;
  logic ref_clk = 0, rst_n = 0, mii_tx_clk = 0, tx_run = 1, reg_wr = 0, reg_rd = 0;
  logic companion_xcvr_link_pin = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = '0, rd_v, rd_f, reg_rdata;
  logic mdio_o, mdio_oe, serial_mgmt_clock, companion_xcvr_enable_pin, serial_mode_tx;
  logic phy_o, phy_oe;
  logic [63:0] fr;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // pull-up on the data line when nobody drives it
  wire mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  always #2 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #6 if (tx_run) mii_tx_clk = ~mii_tx_clk;
  end
  always @(posedge serial_mgmt_clock) if (mdio_oe) fr <= {fr[62:0], mdio_o};
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  mii_management_unit #(.HALF_CYCLES(2)) DUT (.ref_clk, .rst_n, .mii_tx_clk, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .mdio_i, .mdio_o, .mdio_oe, .serial_mgmt_clock,
    .companion_xcvr_link_pin, .companion_xcvr_enable_pin, .serial_mode_tx);
  phy_mgmt_model #(.PHY_ADDR(PHY), .ANSWER(ANS)) u_phy (.rst_n, .mdc(serial_mgmt_clock),
    .mdio(mdio_i), .drv_o(phy_o), .drv_oe(phy_oe));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  // n back-to-back reads; rd_f keeps the first answer, rd_v the last
  task automatic rd(input logic [7:0] a, input int n);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk);
    rd_f = reg_rdata;
    repeat (n - 1) @(negedge ref_clk);
    reg_rd = 0;
    rd_v = reg_rdata;
  endtask
  // a frame is always 64 clock rises; polling would eat the answered flag
  task automatic frame(input logic [31:0] c);
    fr = '0;
    wr(CTRL_OFFSET, c);
    repeat (64) @(posedge serial_mgmt_clock);
    repeat (8) @(negedge ref_clk);
    rd(CTRL_OFFSET, 2);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    rd(CTRL_OFFSET, 1);
    chk("ctrl", rd_v, 0);
    rd(CFG_OFFSET, 1);
    chk("cfg", rd_v, 32'h5C);
    rd(8'h3C, 1);
    chk("unmapped", rd_v, 0);
    $display("reset values done");
    wr(DATA_OFFSET, 32'hFFFFA5C3);
    rd(DATA_OFFSET, 1);
    chk("data", rd_v, 32'hA5C3);
    frame({18'h0, PHY, 5'h0A, 4'h2});
    chk("write busy", rd_f[1:0], 0);
    chk("write frame", fr, {PREAMBLE, START_PAT, OP_WRITE, PHY, 5'h0A, TA_WRITE, 16'hA5C3});
    $display("write frame done");
    frame({18'h0, PHY, 5'h1F, 4'h1});
    chk("read ctrl", rd_f, {18'h0, PHY, 5'h1F, 4'h8});
    chk("flag cleared", rd_v, {18'h0, PHY, 5'h1F, 4'h0});
    chk("read head", fr[45:0], {PREAMBLE, START_PAT, OP_READ, PHY, 5'h1F});
    rd(DATA_OFFSET, 1);
    chk("read data", rd_v, ANS);
    wr(CTRL_OFFSET, 32'h8);
    rd(CTRL_OFFSET, 2);
    chk("flag", rd_v, 0);
    frame({18'h0, 5'h03, 5'h01, 4'h1});
    chk("no answer", rd_f[3], 0);
    rd(DATA_OFFSET, 1);
    chk("idle data", rd_v, 32'hFFFF);
    $display("read frames done");
    tx_run = 0;
    wr(CFG_OFFSET, 32'hC023);
    repeat (12) @(negedge ref_clk);
    chk("alt out", {serial_mgmt_clock, mdio_oe, mdio_o, companion_xcvr_enable_pin}, 4'hD);
    chk("sys clock", serial_mode_tx, 1);
    rd(CFG_OFFSET, 1);
    chk("cfg out", rd_v, 32'hC027);
    wr(CFG_OFFSET, 32'h00C0);
    repeat (12) @(negedge ref_clk);
    chk("alt in", {serial_mgmt_clock, mdio_oe, companion_xcvr_enable_pin, serial_mode_tx}, 1);
    rd(CFG_OFFSET, 1);
    chk("cfg in", rd_v, 32'h00CC);
    tx_run = 1;
    companion_xcvr_link_pin = 0;
    repeat (12) @(negedge ref_clk);
    chk("mode", serial_mode_tx, 0);
    rd(CFG_OFFSET, 1);
    chk("link", rd_v, 32'h00C8);
    wr(CFG_OFFSET, 32'h10);
    $display("config done");
    end_of_test();
  end
endmodule
